//--- logic/ops_pkg.sv
// Package: memory map, field layout, command codes and lookup tables for the parameter store
`default_nettype none
package ops_pkg;

  localparam int NV_BYTES = 8;
  localparam int NV_AW    = 3;

  localparam logic [7:0] ADDR_CAL0  = 8'h00;
  localparam logic [7:0] ADDR_CAL1  = 8'h01;
  localparam logic [7:0] ADDR_THR   = 8'h02;
  localparam logic [7:0] ADDR_CUR   = 8'h03;
  localparam logic [7:0] ADDR_VEL   = 8'h04;
  localparam logic [7:0] ADDR_MOT   = 8'h05;
  localparam logic [7:0] ADDR_SEC   = 8'h06;
  localparam logic [7:0] ADDR_LOCK  = 8'h07;
  localparam logic [7:0] ADDR_LAST  = 8'h07;

  localparam int BIT_GLOCK = 0;
  localparam int BIT_TLOCK = 1;

  typedef enum logic [1:0] {
    OPS_CMD_NONE,
    OPS_CMD_PROGRAM,
    OPS_CMD_READBACK,
    OPS_CMD_PARAM_WRITE
  } ops_cmd_t;

  typedef enum logic [1:0] {
    OPS_ST_OK,
    OPS_ST_LOCKED,
    OPS_ST_BAD_ADDR
  } ops_status_t;

  // Motion parameter set as held in RAM
  typedef struct packed {
    logic [3:0]  abs_thr;
    logic [3:0]  run_cur;
    logic [3:0]  hold_cur;
    logic [3:0]  vmax;
    logic [3:0]  vmin;
    logic        shaft;
    logic [3:0]  acc;
    logic [10:0] fallback;
    logic [3:0]  rel_thr;
    logic [1:0]  step_mode;
  } ops_param_t;

  localparam logic [10:0] FALLBACK_OFF   = 11'h400;
  localparam logic [10:0] FALLBACK_MASK  = 11'h7fc;
  localparam logic [3:0]  HOLD_ZERO_CODE = 4'hf;
  localparam logic [3:0]  FLOOR_CUR_CODE = 4'h0;
  localparam int          HOLD_FLOOR_CYC = 16;

  localparam int ABS_STEP_MV = 500;
  localparam int REL_STEP_MV = 250;

  localparam logic [9:0] CUR_MA [16] = '{
    10'd59, 10'd71, 10'd84, 10'd100, 10'd119, 10'd141, 10'd168, 10'd200,
    10'd238, 10'd283, 10'd336, 10'd400, 10'd476, 10'd566, 10'd673, 10'd800};
  localparam logic [9:0] VMAX_FS [16] = '{
    10'd99, 10'd136, 10'd167, 10'd197, 10'd213, 10'd228, 10'd243, 10'd273,
    10'd303, 10'd334, 10'd364, 10'd395, 10'd456, 10'd546, 10'd729, 10'd973};
  localparam logic [15:0] ACC_FS [16] = '{
    16'd49, 16'd218, 16'd1004, 16'd3609, 16'd6228, 16'd8848, 16'd11409, 16'd13970,
    16'd16531, 16'd19092, 16'd21886, 16'd24447, 16'd27008, 16'd29570, 16'd34925, 16'd40047};

  // Microsteps per full step for each step mode
  localparam logic [4:0] USTEP [4] = '{5'd2, 5'd4, 5'd8, 5'd16};

endpackage
`default_nettype wire

//--- logic/ops_if.sv
// Interface: command and answer path between bus master and parameter store
`default_nettype none
interface ops_if;
  import ops_pkg::*;
  logic       cmd_valid;
  ops_cmd_t   cmd;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  ops_param_t cmd_param;
  logic       cmd_ready;
  logic       rsp_valid;
  ops_status_t rsp_status;
  logic [7:0] rsp_data;

  modport dev  (input cmd_valid, cmd, cmd_addr, cmd_data, cmd_param,
                output cmd_ready, rsp_valid, rsp_status, rsp_data);
  modport host (output cmd_valid, cmd, cmd_addr, cmd_data, cmd_param,
                input cmd_ready, rsp_valid, rsp_status, rsp_data);
endinterface
`default_nettype wire

//--- logic/ops_store.sv
// Device end: nonvolatile store, lock handling, RAM parameters and decoding
`default_nettype none
module ops_store
  import ops_pkg::*;
#(
  parameter logic [7:0] FACTORY_CAL0 = 8'h00, // Arbitrary calibration content
  parameter logic [7:0] FACTORY_CAL1 = 8'h00  // Arbitrary calibration content
) (
  input  wire logic  mclk,             // Clock
  input  wire logic  reset_n,          // Power-on reset, active low
  ops_if.dev         bus,              // Command path
  input  wire logic  hardwired_addr_pin, // Address pin from outside
  input  wire logic  addr_pin_ok,      // Pin connection sensed, from outside
  input  wire logic  motion_stopped,   // Motion controller idle
  input  wire logic  continuous_speed_mode, // Running in velocity mode
  input  wire logic  bad_zap_inject,   // Unused zap disturbance, tie low
  output logic [6:0] node_addr,        // Bus node address
  output logic [9:0] coil_ma,          // Coil current target in mA
  output logic       bridge_off,       // Regulator off, low side grounded
  output logic [9:0] vmax_fs,          // Max speed full steps/s
  output logic [9:0] vmin_fs,          // Min speed full steps/s
  output logic [15:0] acc_fs,          // Ramp rate full steps/s2
  output logic [4:0] microstep_resolution, // Microsteps per full step
  output logic       dir_cw,           // Direction for positioning
  output logic [12:0] stall_abs_threshold, // Absolute threshold mV, 0 off
  output logic [11:0] stall_rel_threshold, // Relative threshold mV, 0 off
  output logic       goto_fallback,    // Drive to fallback position
  output logic [15:0] fallback_position // Fallback target position
);

  typedef struct packed {
    logic [NV_BYTES-1:0][7:0] fuse;
    logic                     loaded;
    ops_param_t               ram;
    logic [3:0]               node_bits;
    logic [1:0]               pin_s;
    logic [1:0]               hw_s;
    logic                     pin_ok_q;
    logic                     rsp_valid;
    ops_status_t              rsp_status;
    logic [7:0]               rsp_data;
    logic [4:0]               hold_cnt;
    logic                     bridge_off;
    logic [9:0]               coil_ma;
    logic                     fallback_go;
  } ops_store_state_t;

  ops_store_state_t s, next_s;

  function automatic ops_param_t decode_fuse(input logic [NV_BYTES-1:0][7:0] f);
    ops_param_t p;
    p.abs_thr   = f[ADDR_THR[NV_AW-1:0]][7:4];
    p.run_cur   = f[ADDR_CUR[NV_AW-1:0]][7:4];
    p.hold_cur  = f[ADDR_CUR[NV_AW-1:0]][3:0];
    p.vmax      = f[ADDR_VEL[NV_AW-1:0]][7:4];
    p.vmin      = f[ADDR_VEL[NV_AW-1:0]][3:0];
    p.fallback  = {f[ADDR_MOT[NV_AW-1:0]][7:5], f[ADDR_SEC[NV_AW-1:0]][7:2], 2'b00};
    p.shaft     = f[ADDR_MOT[NV_AW-1:0]][4];
    p.acc       = f[ADDR_MOT[NV_AW-1:0]][3:0];
    p.rel_thr   = f[ADDR_LOCK[NV_AW-1:0]][7:4];
    p.step_mode = f[ADDR_LOCK[NV_AW-1:0]][3:2];
    return p;
  endfunction

  logic [NV_AW-1:0] idx;
  logic             locked;
  logic [7:0]       burn;

  always_comb begin
    next_s = s;
    idx    = bus.cmd_addr[NV_AW-1:0];
    locked = s.fuse[ADDR_LOCK[NV_AW-1:0]][BIT_GLOCK] ||
             (s.fuse[ADDR_LOCK[NV_AW-1:0]][BIT_TLOCK] && bus.cmd_addr <= ADDR_CAL1);
    burn   = bus.cmd_data & ~s.fuse[idx];
    next_s.rsp_valid = 1'b0;
    next_s.pin_s = {s.pin_s[0], addr_pin_ok};
    next_s.hw_s  = {s.hw_s[0], hardwired_addr_pin};
    next_s.pin_ok_q = s.pin_s[1];
    if (!s.loaded) begin
      next_s.loaded    = 1'b1;
      next_s.ram       = decode_fuse(s.fuse);
      next_s.node_bits = s.fuse[ADDR_THR[NV_AW-1:0]][3:0];
    end else if (bus.cmd_valid) begin
      next_s.rsp_valid  = 1'b1;
      next_s.rsp_status = OPS_ST_OK;
      next_s.rsp_data   = 8'h00;
      unique case (bus.cmd)
        OPS_CMD_PROGRAM: begin
          if (bus.cmd_addr > ADDR_LAST) begin
            next_s.rsp_status = OPS_ST_BAD_ADDR;
          end else if (locked) begin
            next_s.rsp_status = OPS_ST_LOCKED;
          end else begin
            next_s.fuse[idx] = s.fuse[idx] | burn;
          end
        end
        OPS_CMD_READBACK: begin
          if (bus.cmd_addr > ADDR_LAST) begin
            next_s.rsp_status = OPS_ST_BAD_ADDR;
          end else begin
            next_s.rsp_data = s.fuse[idx];
          end
        end
        OPS_CMD_PARAM_WRITE: begin
          next_s.ram = bus.cmd_param;
          next_s.ram.fallback = bus.cmd_param.fallback & FALLBACK_MASK;
        end
        OPS_CMD_NONE: begin
          next_s.rsp_valid = 1'b0;
        end
      endcase
    end
    // Current reduction on standstill
    if (!motion_stopped) begin
      next_s.coil_ma    = CUR_MA[s.ram.run_cur];
      next_s.bridge_off = 1'b0;
      next_s.hold_cnt   = '0;
    end else if (s.ram.hold_cur != HOLD_ZERO_CODE) begin
      next_s.coil_ma    = CUR_MA[s.ram.hold_cur];
      next_s.bridge_off = 1'b0;
    end else begin
      next_s.coil_ma = CUR_MA[FLOOR_CUR_CODE];
      if (s.hold_cnt < 5'(HOLD_FLOOR_CYC)) begin
        next_s.hold_cnt = s.hold_cnt + 5'd1;
      end else begin
        next_s.bridge_off = 1'b1;
      end
    end
    next_s.fallback_go = !s.pin_ok_q && s.loaded && (s.ram.fallback != FALLBACK_OFF);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
      s.fuse[ADDR_CAL0[NV_AW-1:0]] <= FACTORY_CAL0;
      s.fuse[ADDR_CAL1[NV_AW-1:0]] <= FACTORY_CAL1;
      s.fuse[ADDR_LOCK[NV_AW-1:0]][BIT_TLOCK] <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Reset clears all fuse contents except the factory calibration bytes and trim lock bit; model keeps them in flops.
  assign bus.cmd_ready  = s.loaded;
  assign bus.rsp_valid  = s.rsp_valid;
  assign bus.rsp_status = s.rsp_status;
  assign bus.rsp_data   = s.rsp_data;

  assign node_addr = {2'b11, s.node_bits, s.hw_s[1]};
  assign coil_ma   = s.coil_ma;
  assign bridge_off = s.bridge_off;
  assign vmax_fs   = VMAX_FS[s.ram.vmax];
  assign vmin_fs   = (s.ram.vmin == 4'h0) ? VMAX_FS[s.ram.vmax] :
                     10'((14'(VMAX_FS[s.ram.vmax]) * 14'(s.ram.vmin)) >> 5);
  assign acc_fs    = ACC_FS[s.ram.acc];
  assign microstep_resolution = USTEP[s.ram.step_mode];
  assign dir_cw    = continuous_speed_mode ? 1'b0 : s.ram.shaft;
  assign stall_abs_threshold = 13'(s.ram.abs_thr * ABS_STEP_MV);
  assign stall_rel_threshold = 12'(s.ram.rel_thr * REL_STEP_MV);
  assign goto_fallback     = s.fallback_go;
  assign fallback_position = {s.ram.fallback, 5'b00000};

  logic unused_ok;
  assign unused_ok = bad_zap_inject;

endmodule
`default_nettype wire

//--- logic/ops_master.sv
// Host end: issues one command at a time and returns the answer
`default_nettype none
module ops_master
  import ops_pkg::*;
(
  input  wire logic        mclk,        // Clock
  input  wire logic        reset_n,     // Reset, active low
  ops_if.host              bus,         // Command path
  input  wire logic        req_valid,   // User request
  input  wire ops_cmd_t    req_cmd,     // Command kind
  input  wire logic [7:0]  req_addr,    // Byte address
  input  wire logic [7:0]  req_data,    // Byte to program
  input  wire ops_param_t  req_param,   // RAM parameters
  output logic             req_ready,   // Idle, takes request
  output logic             done,        // Answer pulse
  output ops_status_t      done_status, // Answer status
  output logic [7:0]       done_data    // Readback byte
);

  typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} ops_mstate_t;

  typedef struct packed {
    ops_mstate_t st;
    ops_cmd_t    cmd;
    logic [7:0]  addr;
    logic [7:0]  data;
    ops_param_t  param;
    logic        done;
    ops_status_t status;
    logic [7:0]  rdata;
  } ops_master_state_t;

  ops_master_state_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.st)
      M_IDLE: begin
        if (req_valid && req_cmd != OPS_CMD_NONE) begin
          next_s.st    = M_SEND;
          next_s.cmd   = req_cmd;
          next_s.addr  = req_addr;
          next_s.data  = req_data;
          next_s.param = req_param;
        end
      end
      M_SEND: begin
        if (bus.cmd_ready) begin
          next_s.st = M_WAIT;
        end
      end
      M_WAIT: begin
        if (bus.rsp_valid) begin
          next_s.st     = M_IDLE;
          next_s.done   = 1'b1;
          next_s.status = bus.rsp_status;
          next_s.rdata  = bus.rsp_data;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.cmd_valid = (s.st == M_SEND) && bus.cmd_ready;
  assign bus.cmd       = s.cmd;
  assign bus.cmd_addr  = s.addr;
  assign bus.cmd_data  = s.data;
  assign bus.cmd_param = s.param;
  assign req_ready     = (s.st == M_IDLE);
  assign done          = s.done;
  assign done_status   = s.status;
  assign done_data     = s.rdata;

endmodule
`default_nettype wire

//--- test/ops_sva.sv
// Checker: command path assertions for the parameter store
`default_nettype none
module ops_sva
  import ops_pkg::*;
(
  input wire logic        mclk,       // Clock
  input wire logic        reset_n,    // Reset, active low
  input wire logic        cmd_valid,  // Command strobe
  input wire ops_cmd_t    cmd,        // Command kind
  input wire logic [7:0]  cmd_addr,   // Byte address
  input wire logic [7:0]  cmd_data,   // Bits to zap
  input wire logic        cmd_ready,  // Store loaded
  input wire logic        rsp_valid,  // Answer pulse
  input wire ops_status_t rsp_status, // Answer status
  input wire logic [7:0]  rsp_data    // Readback byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic prog;
  logic glock;
  assign take = cmd_valid && cmd_ready && cmd != OPS_CMD_NONE;
  assign prog = take && cmd == OPS_CMD_PROGRAM;
  // Shadow of the general lock fuse
  always_ff @(posedge mclk) begin
    if (!reset_n) glock <= 1'b0;
    else if (prog && cmd_addr == ADDR_LOCK && cmd_data[BIT_GLOCK]) glock <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  property p_answer; take |=> rsp_valid; endproperty
  property p_no_stray; rsp_valid |-> $past(take); endproperty
  property p_bad_addr; prog && cmd_addr > ADDR_LAST |=> rsp_status == OPS_ST_BAD_ADDR; endproperty
  property p_trim; prog && cmd_addr <= ADDR_CAL1 |=> rsp_status == OPS_ST_LOCKED; endproperty
  property p_glock; prog && glock && cmd_addr <= ADDR_LAST |=> rsp_status == OPS_ST_LOCKED; endproperty
  property p_open;
    prog && !glock && cmd_addr inside {[ADDR_THR:ADDR_LAST]} |=> rsp_status == OPS_ST_OK;
  endproperty
  property p_trim_bit; take && cmd == OPS_CMD_READBACK && cmd_addr == ADDR_LOCK |=> rsp_data[BIT_TLOCK]; endproperty
  property p_hold; !rsp_valid && $past(reset_n) |-> $stable(rsp_status) && $stable(rsp_data); endproperty
  property p_loaded; $rose(reset_n) |=> cmd_ready; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_no_stray: assert property (p_no_stray) else $error("stray answer");
  a_bad_addr: assert property (p_bad_addr) else $error("bad address taken");
  a_trim: assert property (p_trim) else $error("trim lock ignored");
  a_glock: assert property (p_glock) else $error("general lock ignored");
  a_open: assert property (p_open) else $error("open byte refused");
  a_trim_bit: assert property (p_trim_bit) else $error("trim bit clear");
  a_hold: assert property (p_hold) else $error("answer moved");
  a_loaded: assert property (p_loaded) else $error("not loaded");
  c_ok: cover property (prog ##1 rsp_status == OPS_ST_OK);
  c_locked: cover property (prog && glock);
  c_param: cover property (take && cmd == OPS_CMD_PARAM_WRITE);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Testbench: both ends joined, random and corner traffic
`default_nettype none
module tb_top
  import ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset_n = 0, req_valid = 0, pin = 1, pin_ok = 1, stopped = 0, cont = 0;
  ops_cmd_t    req_cmd = OPS_CMD_NONE;
  logic [7:0]  req_addr = '0, req_data = '0, done_data, nv [8];
  ops_param_t  p = '0;
  logic        req_ready, done, bridge_off, dir_cw, goto_fb;
  ops_status_t done_status;
  logic [6:0]  node_addr;
  logic [9:0]  coil_ma, vmax_fs, vmin_fs, vm;
  logic [15:0] acc_fs, fb_pos;
  logic [4:0]  ustep;
  logic [12:0] abs_mv;
  logic [11:0] rel_mv;
  int          fail_count = 0, check_count = 0, cycles = 0, seed = 32'h3a82;
  ops_if bus ();
  ops_master u_ops_master (.mclk(mclk), .reset_n(reset_n), .bus(bus), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_data(req_data), .req_param(p), .req_ready(req_ready), .done(done),
    .done_status(done_status), .done_data(done_data));
  ops_store u_ops_store (.mclk(mclk), .reset_n(reset_n), .bus(bus), .hardwired_addr_pin(pin), .addr_pin_ok(pin_ok),
    .motion_stopped(stopped), .continuous_speed_mode(cont), .bad_zap_inject(1'b0), .node_addr(node_addr),
    .coil_ma(coil_ma), .bridge_off(bridge_off), .vmax_fs(vmax_fs), .vmin_fs(vmin_fs), .acc_fs(acc_fs),
    .microstep_resolution(ustep), .dir_cw(dir_cw), .stall_abs_threshold(abs_mv), .stall_rel_threshold(rel_mv),
    .goto_fallback(goto_fb), .fallback_position(fb_pos));
  ops_sva u_ops_sva (.mclk(mclk), .reset_n(reset_n), .cmd_valid(bus.cmd_valid), .cmd(bus.cmd),
    .cmd_addr(bus.cmd_addr), .cmd_data(bus.cmd_data), .cmd_ready(bus.cmd_ready), .rsp_valid(bus.rsp_valid),
    .rsp_status(bus.rsp_status), .rsp_data(bus.rsp_data));
  ////////////////////////////////////////////////////////////////
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic ops_status_t exp_st(input logic [7:0] a);
    if (a > ADDR_LAST) return OPS_ST_BAD_ADDR;
    if (nv[7][BIT_GLOCK] || (nv[7][BIT_TLOCK] && a <= ADDR_CAL1)) return OPS_ST_LOCKED;
    return OPS_ST_OK;
  endfunction
  // One request through the host end, waits for its answer
  task automatic req(input ops_cmd_t c, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(posedge mclk); #1 n++; end
    req_cmd = c;
    req_addr = a;
    req_data = d;
    req_valid = 1;
    @(posedge mclk);
    #1 req_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin @(posedge mclk); #1 n++; end
    if (n == 50) fail_count++;
  endtask
  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    ops_status_t st;
    st = exp_st(a);
    req(OPS_CMD_PROGRAM, a, d);
    check(done_status, st);
    if (st == OPS_ST_OK) nv[a[2:0]] = nv[a[2:0]] | d;
    if (a <= ADDR_LAST) req(OPS_CMD_READBACK, a, 8'h00);
    if (a <= ADDR_LAST) check(done_data, nv[a[2:0]]);
  endtask
  task automatic dump();
    for (int i = 0; i < 8; i++) begin
      req(OPS_CMD_READBACK, 8'(i), 8'h00);
      check(done_data, nv[i]);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) nv[i] = (i == 7) ? 8'h02 : 8'h00;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1;
    @(posedge mclk);
    #1 dump();
    prog(8'h00, 8'h5a);
    prog(8'h01, 8'h01);
    prog(8'h09, 8'h01);
    prog(8'h06, 8'hff);
    prog(8'h06, 8'h00);
    repeat (12) prog(8'(2 + $unsigned($random(seed)) % 5), 8'($random(seed)));
    check(node_addr, {2'b11, 4'h0, pin});
    check(abs_mv, 0);
    for (int k = 0; k < 6; k++) begin
      p = 42'({$random(seed), $random(seed)});
      if (k == 0) begin
        p.vmin = 0;
        p.hold_cur = HOLD_ZERO_CODE;
        p.fallback = 11'h403;
      end
      cont = k[0];
      pin = k[1];
      req(OPS_CMD_PARAM_WRITE, 8'h00, 8'h00);
      check(done_status, OPS_ST_OK);
      repeat (2) @(posedge mclk);
      #1 vm = VMAX_FS[p.vmax];
      check(vmax_fs, vm);
      check(vmin_fs, p.vmin == 0 ? vm : (vm * p.vmin) >> 5);
      check(acc_fs, ACC_FS[p.acc]);
      check(ustep, USTEP[p.step_mode]);
      check(abs_mv, p.abs_thr * ABS_STEP_MV);
      check(rel_mv, p.rel_thr * REL_STEP_MV);
      check(dir_cw, cont ? 1'b0 : p.shaft);
      check(fb_pos, {p.fallback & FALLBACK_MASK, 5'b0});
      check(coil_ma, CUR_MA[p.run_cur]);
      check(node_addr, {2'b11, 4'h0, pin});
      stopped = 1;
      repeat (3) @(posedge mclk);
      #1 check(coil_ma, CUR_MA[p.hold_cur == HOLD_ZERO_CODE ? 4'h0 : p.hold_cur]);
      check(bridge_off, 1'b0);
      repeat (20) @(posedge mclk);
      #1 check(bridge_off, p.hold_cur == HOLD_ZERO_CODE);
      pin_ok = 0;
      repeat (6) @(posedge mclk);
      #1 check(goto_fb, (p.fallback & FALLBACK_MASK) != FALLBACK_OFF);
      pin_ok = 1;
      stopped = 0;
      repeat (6) @(posedge mclk);
      #1;
    end
    prog(8'h07, 8'h01);
    prog(8'h03, 8'hff);
    dump();
    reset_n = 0;
    for (int i = 0; i < 8; i++) nv[i] = (i == 7) ? 8'h02 : 8'h00;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1;
    @(posedge mclk);
    #1 dump();
    tally_and_finish();
  end
endmodule
`default_nettype wire
